// >>> rfl_pkg.sv
// Purpose: constants, tables and helpers for the repeated-frame radio link
// Assumes: 200 MHz system clock, 2.4 kbps link rate
// Notes: preamble, postamble, symbol and message tables are local choices
// Overview of operation
// - Each 6-bit line symbol of a digit is looked up and turned into a 4-bit value.
// - Each decoded 4-bit digit value is turned into an 8-bit segment pattern for the LCD.
// - The display timer counts its dwell and pulses advance when the dwell completes.
// - On each advance the load sequencer steps its state number and then fires a load pulse.
// - A gap counter sets the spacing between successive loads of one data state.
// - A repeat counter limits how many times the same data is sent per state.
// - The serializer pops state data from the FIFO whenever it is idle and shifts it out as the transmit bit.
// - After an edge on the received line the sampling counter runs and times the sample.
// - The sampling counter is sized from clock and link rate (4 bits at 32.7 kHz, 2.4 kbps).
// - Counter width and terminal value are derived from clock and rate, so a new rate recomputes them.
// - Every new edge on the received line restarts the sampling counter to limit drift.
// - The received pin is shifted into a 3-bit edge register each cycle; an edge there starts sampling.
// - Sampling happens about three quarters into each bit and fills a 36-bit frame register.
// - A postamble in the top 12 frame bits stores the data into the next of four copies; two equal copies display.
// - Each data state is loaded four times with a fixed gap between transmissions.
package rfl_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int BAUD_BPS = 2400;
   localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
   localparam int SAMPLE_CYC = (BIT_CYC * 3) / 4;
   localparam int DWELL_MS = 500;
   localparam int DWELL_CYC = (CLK_HZ / 1000) * DWELL_MS;
   localparam int GAP_MS = 20;
   localparam int GAP_CYC = (CLK_HZ / 1000) * GAP_MS;
   localparam int LCD_HALF_MS = 10;
   localparam int LCD_HALF_CYC = (CLK_HZ / 1000) * LCD_HALF_MS;
   localparam int FRAME_W = 36;
   localparam int WORD_W = 12;
   localparam int SYM_W = 6;
   localparam int NIB_W = 4;
   localparam int SEG_W = 8;
   localparam int COPIES = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int STATE_W = 3;
   localparam logic [11:0] PREAMBLE = 12'hAAA;
   localparam logic [11:0] POSTAMBLE = 12'h3C5;
   localparam logic TX_IDLE = 1'h0;
   localparam logic [5:0] SYM_TAB [16] = '{6'h0D, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h19, 6'h1A,
      6'h1C, 6'h23, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2C, 6'h31, 6'h32};

   function automatic logic [3:0] symbol_to_nibble(input logic [5:0] s);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (SYM_TAB[i] == s) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : symbol_to_nibble

   function automatic logic [7:0] nibble_to_segments(input logic [3:0] n);
      logic [7:0] r;
      case (n)
         4'h0: r = 8'h3F;
         4'h1: r = 8'h06;
         4'h2: r = 8'h5B;
         4'h3: r = 8'h4F;
         4'h4: r = 8'h66;
         4'h5: r = 8'h6D;
         4'h6: r = 8'h7D;
         4'h7: r = 8'h07;
         4'h8: r = 8'h7F;
         4'h9: r = 8'h6F;
         4'hA: r = 8'h77;
         4'hB: r = 8'h7C;
         4'hC: r = 8'h39;
         4'hD: r = 8'h5E;
         4'hE: r = 8'h79;
         default: r = 8'h71;
      endcase
      return r;
   endfunction : nibble_to_segments

   function automatic logic [11:0] state_word(input logic [2:0] s);
      logic [7:0] p;
      case (s)
         3'h0: p = 8'hC0;
         3'h1: p = 8'h0E;
         3'h2: p = 8'hA5;
         3'h3: p = 8'h12;
         3'h4: p = 8'h34;
         3'h5: p = 8'hDE;
         3'h6: p = 8'hF9;
         default: p = 8'h78;
      endcase
      return {SYM_TAB[p[7:4]], SYM_TAB[p[3:0]]};
   endfunction : state_word
endpackage : rfl_pkg

// >>> rfl_stream_if.sv
// Purpose: valid/ready word stream between the link modules
// Assumes: one clock shared by both ends
// Notes: data is held stable by the source while valid and not ready
interface rfl_stream_if #(parameter int W = 12) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : rfl_stream_if

// >>> rfl_fifo.sv
// Purpose: small first-in first-out buffer for frame data words
// Assumes: DEPTH is a power of two
// Notes: ready low when full, valid low when empty
module rfl_fifo #(
   parameter int W = 12,
   parameter int DEPTH = 8
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   rfl_stream_if.snk in_s,
   rfl_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic full, empty, do_wr, do_rd;

   always_comb begin
      full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
      empty = (wr_ptr == rd_ptr);
      in_s.ready = !full;
      out_s.valid = !empty;
      out_s.data = mem[rd_ptr[AW-1:0]];
      do_wr = in_s.valid && !full;
      do_rd = out_s.ready && !empty;
      next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else if (ce_i) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_s.data;
         end
      end
   end
endmodule : rfl_fifo

// >>> rfl_link_top.sv
// Purpose: transmit pacing, serializer, receive sampler and vote for the radio link
// Assumes: rf_rx_i is asynchronous to clock_i
// Notes: long counts are parameters so a bench can shorten them
module rfl_link_top
   import rfl_pkg::*;
#(
   parameter int unsigned BIT_CYCLES = rfl_pkg::BIT_CYC,
   parameter int unsigned SAMPLE_CYCLES = rfl_pkg::SAMPLE_CYC,
   parameter int unsigned DWELL_CYCLES = rfl_pkg::DWELL_CYC,
   parameter int unsigned GAP_CYCLES = rfl_pkg::GAP_CYC,
   parameter int unsigned LCD_HALF_CYCLES = rfl_pkg::LCD_HALF_CYC
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic rf_rx_i,
   output logic rf_tx_o,
   output logic lcd_backplane_o,
   output logic [rfl_pkg::SEG_W-1:0] tx_seg_hi_o,
   output logic [rfl_pkg::SEG_W-1:0] tx_seg_lo_o,
   output logic [rfl_pkg::SEG_W-1:0] rx_seg_hi_o,
   output logic [rfl_pkg::SEG_W-1:0] rx_seg_lo_o,
   output logic rx_word_valid_o,
   output logic [rfl_pkg::STATE_W-1:0] tx_state_o
);
   import rfl_pkg::*;

   localparam int BCNT_W = $clog2(BIT_CYCLES + 1);

   typedef enum logic {SER_IDLE, SER_SEND} rfl_ser_t;

   rfl_stream_if #(.W(WORD_W)) push_s ();
   rfl_stream_if #(.W(WORD_W)) pop_s ();

   rfl_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .in_s(push_s),
      .out_s(pop_s)
   );

   // display timer and backplane
   logic [31:0] dwell_cnt, next_dwell_cnt, lcd_cnt, next_lcd_cnt;
   logic lcd_bp, next_lcd_bp, advance;

   always_comb begin
      advance = (dwell_cnt == 32'(DWELL_CYCLES - 1));
      next_dwell_cnt = advance ? 32'h0 : dwell_cnt + 32'h1;
      next_lcd_bp = lcd_bp;
      next_lcd_cnt = lcd_cnt + 32'h1;
      if (lcd_cnt == 32'(LCD_HALF_CYCLES - 1)) begin
         next_lcd_cnt = 32'h0;
         next_lcd_bp = !lcd_bp;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         dwell_cnt <= 32'h0;
         lcd_cnt <= 32'h0;
         lcd_bp <= 1'b0;
      end else if (ce_i) begin
         dwell_cnt <= next_dwell_cnt;
         lcd_cnt <= next_lcd_cnt;
         lcd_bp <= next_lcd_bp;
      end
   end

   // load sequencer
   logic [STATE_W-1:0] state_num, next_state_num;
   logic [2:0] repeat_counter, next_repeat_counter;
   logic [31:0] gap_counter, next_gap_counter;
   logic seq_busy, next_seq_busy, load_pulse;

   always_comb begin
      next_state_num = state_num;
      next_repeat_counter = repeat_counter;
      next_gap_counter = gap_counter;
      next_seq_busy = seq_busy;
      load_pulse = 1'b0;
      if (advance) begin
         next_state_num = state_num + 3'h1;
         next_repeat_counter = 3'h0;
         next_gap_counter = 32'h0;
         next_seq_busy = 1'b1;
      end else if (seq_busy) begin
         if (gap_counter != 32'h0) begin
            next_gap_counter = gap_counter - 32'h1;
         end else if (push_s.ready) begin
            load_pulse = 1'b1;
            next_repeat_counter = repeat_counter + 3'h1;
            next_gap_counter = 32'(GAP_CYCLES - 1);
            if (repeat_counter == 3'(COPIES - 1)) begin
               next_seq_busy = 1'b0;
            end
         end
      end
      push_s.valid = load_pulse;
      push_s.data = state_word(state_num);
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_num <= '0;
         repeat_counter <= 3'h0;
         gap_counter <= 32'h0;
         seq_busy <= 1'b1;
      end else if (ce_i) begin
         state_num <= next_state_num;
         repeat_counter <= next_repeat_counter;
         gap_counter <= next_gap_counter;
         seq_busy <= next_seq_busy;
      end
   end

   // bit serializer
   rfl_ser_t ser_state, next_ser_state;
   logic [FRAME_W-1:0] ser_frame, next_ser_frame;
   logic [5:0] ser_bit, next_ser_bit;
   logic [BCNT_W-1:0] ser_baud, next_ser_baud;
   logic tx_bit, next_tx_bit;

   always_comb begin
      next_ser_state = ser_state;
      next_ser_frame = ser_frame;
      next_ser_bit = ser_bit;
      next_ser_baud = ser_baud;
      next_tx_bit = tx_bit;
      pop_s.ready = (ser_state == SER_IDLE);
      case (ser_state)
         SER_IDLE: begin
            if (pop_s.valid) begin
               next_ser_frame = {POSTAMBLE, pop_s.data, PREAMBLE};
               next_ser_bit = 6'h0;
               next_ser_baud = '0;
               next_tx_bit = PREAMBLE[0];
               next_ser_state = SER_SEND;
            end
         end
         SER_SEND: begin
            if (ser_baud == BCNT_W'(BIT_CYCLES - 1)) begin
               next_ser_baud = '0;
               if (ser_bit == 6'(FRAME_W - 1)) begin
                  next_tx_bit = TX_IDLE;
                  next_ser_state = SER_IDLE;
               end else begin
                  next_ser_bit = ser_bit + 6'h1;
                  next_ser_frame = {1'b0, ser_frame[FRAME_W-1:1]};
                  next_tx_bit = ser_frame[1];
               end
            end else begin
               next_ser_baud = ser_baud + 1'b1;
            end
         end
         default: begin
            next_ser_state = SER_IDLE;
            next_tx_bit = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ser_state <= SER_IDLE;
         ser_frame <= '0;
         ser_bit <= 6'h0;
         ser_baud <= '0;
         tx_bit <= TX_IDLE;
      end else if (ce_i) begin
         ser_state <= next_ser_state;
         ser_frame <= next_ser_frame;
         ser_bit <= next_ser_bit;
         ser_baud <= next_ser_baud;
         tx_bit <= next_tx_bit;
      end
   end

   // receive sampler and vote
   logic rx_meta, rx_sync, rx_edge;
   logic [2:0] rx_edge_shift, next_rx_edge_shift;
   logic samp_run, next_samp_run;
   logic [BCNT_W-1:0] samp_cnt, next_samp_cnt;
   logic [FRAME_W-1:0] rx_frame, next_rx_frame;
   logic [WORD_W-1:0] capture_copy [COPIES];
   logic [WORD_W-1:0] next_capture_copy [COPIES];
   logic [WORD_W-1:0] cand [COPIES];
   logic [1:0] cap_idx, next_cap_idx;
   logic [WORD_W-1:0] rx_word, next_rx_word;
   logic rx_valid, next_rx_valid;

   always_comb begin
      next_rx_edge_shift = {rx_edge_shift[1:0], rx_sync};
      rx_edge = rx_edge_shift[1] ^ rx_edge_shift[0];
      next_samp_run = samp_run;
      next_samp_cnt = samp_cnt;
      next_rx_frame = rx_frame;
      next_capture_copy = capture_copy;
      next_cap_idx = cap_idx;
      next_rx_word = rx_word;
      next_rx_valid = rx_valid;
      cand = capture_copy;
      cand[COPIES-1] = rx_frame[2*WORD_W-1:WORD_W];
      if (rx_edge) begin
         next_samp_run = 1'b1;
         next_samp_cnt = '0;
      end else if (samp_run) begin
         next_samp_cnt = (samp_cnt == BCNT_W'(BIT_CYCLES - 1)) ? '0 : samp_cnt + 1'b1;
      end
      if (rx_frame[FRAME_W-1:FRAME_W-WORD_W] == POSTAMBLE) begin
         next_capture_copy[cap_idx] = rx_frame[2*WORD_W-1:WORD_W];
         next_cap_idx = cap_idx + 2'h1;
         next_rx_frame = '0;
         if (cap_idx == 2'(COPIES - 1)) begin
            for (int i = 0; i < COPIES; i++) begin
               for (int j = i + 1; j < COPIES; j++) begin
                  if (cand[i] == cand[j]) begin
                     next_rx_word = cand[i];
                     next_rx_valid = 1'b1;
                  end
               end
            end
         end
      end else if (samp_run && !rx_edge && samp_cnt == BCNT_W'(SAMPLE_CYCLES - 1)) begin
         next_rx_frame = {rx_edge_shift[0], rx_frame[FRAME_W-1:1]};
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rx_meta <= 1'b0;
         rx_sync <= 1'b0;
         rx_edge_shift <= 3'h0;
         samp_run <= 1'b0;
         samp_cnt <= '0;
         rx_frame <= '0;
         cap_idx <= 2'h0;
         rx_word <= '0;
         rx_valid <= 1'b0;
         for (int i = 0; i < COPIES; i++) begin
            capture_copy[i] <= '0;
         end
      end else if (ce_i) begin
         rx_meta <= rf_rx_i;
         rx_sync <= rx_meta;
         rx_edge_shift <= next_rx_edge_shift;
         samp_run <= next_samp_run;
         samp_cnt <= next_samp_cnt;
         rx_frame <= next_rx_frame;
         cap_idx <= next_cap_idx;
         rx_word <= next_rx_word;
         rx_valid <= next_rx_valid;
         capture_copy <= next_capture_copy;
      end
   end

   // segment drive, inverted against the backplane
   logic [SEG_W-1:0] tx_hi, tx_lo, rx_hi, rx_lo;
   logic [SEG_W-1:0] next_tx_hi, next_tx_lo, next_rx_hi, next_rx_lo;
   logic [WORD_W-1:0] tx_word;

   always_comb begin
      tx_word = state_word(state_num);
      next_tx_hi = nibble_to_segments(symbol_to_nibble(tx_word[11:6])) ^ {SEG_W{lcd_bp}};
      next_tx_lo = nibble_to_segments(symbol_to_nibble(tx_word[5:0])) ^ {SEG_W{lcd_bp}};
      next_rx_hi = nibble_to_segments(symbol_to_nibble(rx_word[11:6])) ^ {SEG_W{lcd_bp}};
      next_rx_lo = nibble_to_segments(symbol_to_nibble(rx_word[5:0])) ^ {SEG_W{lcd_bp}};
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         tx_hi <= '0;
         tx_lo <= '0;
         rx_hi <= '0;
         rx_lo <= '0;
      end else if (ce_i) begin
         tx_hi <= next_tx_hi;
         tx_lo <= next_tx_lo;
         rx_hi <= next_rx_hi;
         rx_lo <= next_rx_lo;
      end
   end

   assign rf_tx_o = tx_bit;
   assign lcd_backplane_o = lcd_bp;
   assign tx_seg_hi_o = tx_hi;
   assign tx_seg_lo_o = tx_lo;
   assign rx_seg_hi_o = rx_hi;
   assign rx_seg_lo_o = rx_lo;
   assign rx_word_valid_o = rx_valid;
   assign tx_state_o = state_num;
endmodule : rfl_link_top

// >>> rfl_link_properties.sv
// Purpose: port-level checks of the radio link top
// Assumes: dwell count advances only on enabled cycles
// Notes: bound into rfl_link_top
module rfl_link_properties
   import rfl_pkg::*;
#(
   parameter int unsigned BIT_CYCLES = 16,
   parameter int unsigned DWELL_CYCLES = 4000
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic rf_rx_i,
   input wire logic rf_tx_o,
   input wire logic lcd_backplane_o,
   input wire logic [rfl_pkg::SEG_W-1:0] tx_seg_hi_o,
   input wire logic [rfl_pkg::SEG_W-1:0] tx_seg_lo_o,
   input wire logic [rfl_pkg::SEG_W-1:0] rx_seg_hi_o,
   input wire logic [rfl_pkg::SEG_W-1:0] rx_seg_lo_o,
   input wire logic rx_word_valid_o,
   input wire logic [rfl_pkg::STATE_W-1:0] tx_state_o
);
   logic [2:0] prev_state;
   logic seen;
   logic [31:0] dwell_cnt;
   logic [31:0] tx_run;
   logic [31:0] since_rst;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);
   // cycles since last state change, last tx edge and reset
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         prev_state <= 3'h0;
         seen <= 1'b0;
         dwell_cnt <= 32'h0;
         tx_run <= 32'h0;
         since_rst <= 32'h0;
      end else begin
         prev_state <= tx_state_o;
         seen <= seen | (tx_state_o != prev_state);
         dwell_cnt <= (tx_state_o != prev_state) ? 32'h0 : dwell_cnt + 32'(ce_i);
         tx_run <= $changed(rf_tx_o) ? 32'h0 : tx_run + 32'h1;
         since_rst <= since_rst + 32'h1;
      end
   end
   reset_values_a: assert property ($past(sys_rst_i) |->
      !rf_tx_o && tx_state_o == 3'h0 && !rx_word_valid_o) else $error("reset values wrong");
   tx_idle_a: assert property ($fell(sys_rst_i) |-> ##1 !rf_tx_o ##1 !rf_tx_o)
      else $error("tx line not idle after reset");
   vote_sticky_a: assert property (rx_word_valid_o |=> rx_word_valid_o)
      else $error("word valid dropped");
   state_step_a: assert property ($changed(tx_state_o) |->
      tx_state_o == 3'($past(tx_state_o) + 3'h1)) else $error("state did not step by one");
   dwell_time_a: assert property (seen && tx_state_o != prev_state |->
      dwell_cnt == DWELL_CYCLES - 1) else $error("dwell length wrong");
   bit_hold_a: assert property ($changed(rf_tx_o) |-> tx_run >= BIT_CYCLES - 1)
      else $error("tx bit too short");
   first_vote_a: assert property ($rose(rx_word_valid_o) |->
      since_rst >= 4 * 35 * BIT_CYCLES) else $error("vote before four frames");
   seg_follow_a: assert property ($changed(tx_state_o) |-> ##[1:2] $changed(tx_seg_hi_o))
      else $error("tx digits did not follow state");
endmodule : rfl_link_properties

bind rfl_link_top rfl_link_properties #(.BIT_CYCLES(BIT_CYCLES), .DWELL_CYCLES(DWELL_CYCLES))
   u_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .rf_rx_i(rf_rx_i),
   .rf_tx_o(rf_tx_o), .lcd_backplane_o(lcd_backplane_o), .tx_seg_hi_o(tx_seg_hi_o),
   .tx_seg_lo_o(tx_seg_lo_o), .rx_seg_hi_o(rx_seg_hi_o), .rx_seg_lo_o(rx_seg_lo_o),
   .rx_word_valid_o(rx_word_valid_o), .tx_state_o(tx_state_o));

// >>> rfl_rf_model.sv
// Purpose: radio module data pin seen by the link receiver
// Assumes: loop_i echoes the transmit bit back
// Notes: pin toggles every cycle outside injected frames while loop_i is low
module rfl_rf_model (
   input wire logic clock_i,
   input wire logic tx_i,
   input wire logic loop_i,
   output logic rx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import rfl_pkg::*;
   logic inj = 1'b0;
   logic busy = 1'b0;
   assign rx_o = loop_i ? tx_i : inj;
   // noise while no frame is sent
   always @(posedge clock_i) begin
      if (!busy) begin
         inj <= ~inj;
      end
   end
   task automatic send_frame(input logic [11:0] w, input int per);
      logic [35:0] f;
      f = {POSTAMBLE, w, PREAMBLE};
      busy = 1'b1;
      for (int i = 0; i < 36; i++) begin
         inj <= f[i];
         repeat (per) @(posedge clock_i);
      end
      #1;
      busy = 1'b0;
   endtask : send_frame
endmodule : rfl_rf_model

// >>> tb_top.sv
// Purpose: self-checking bench for the radio link top
// Assumes: long counts shortened through parameters
// Notes: rf model injects frames first, then loops tx back
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rfl_pkg::*;
   localparam int BITC = 16;
   localparam int GAPC = 700;
   localparam int DWELLC = 4000;
   localparam int LCDH = 50;
   localparam logic [7:0] MSG [8] = '{8'hC0, 8'h0E, 8'hA5, 8'h12, 8'h34, 8'hDE, 8'hF9, 8'h78};
   localparam logic [7:0] SEG [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
      8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
   logic clock_i, sys_rst_i, ce_i, rf_rx, rf_tx, bp, valid, loop;
   logic [7:0] txh, txl, rxh, rxl;
   logic [2:0] st;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int rel_cyc = 0;
   rfl_link_top #(.BIT_CYCLES(BITC), .SAMPLE_CYCLES(12), .DWELL_CYCLES(DWELLC),
      .GAP_CYCLES(GAPC), .LCD_HALF_CYCLES(LCDH)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .ce_i(ce_i), .rf_rx_i(rf_rx), .rf_tx_o(rf_tx), .lcd_backplane_o(bp), .tx_seg_hi_o(txh),
      .tx_seg_lo_o(txl), .rx_seg_hi_o(rxh), .rx_seg_lo_o(rxl), .rx_word_valid_o(valid),
      .tx_state_o(st));
   rfl_rf_model u_rf (.clock_i(clock_i), .tx_i(rf_tx), .loop_i(loop), .rx_o(rf_rx));
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   always @(posedge clock_i) begin
      cyc = cyc + 1;
      if (cyc > 60000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic do_reset();
      sys_rst_i = 1'b1;
      repeat (16) @(posedge clock_i);
      #1;
      check(36'({rf_tx, st, valid}), 36'h0);
      sys_rst_i = 1'b0;
      rel_cyc = cyc;
   endtask : do_reset
   task automatic check_disp(input logic [7:0] rxw, input logic [7:0] txw, input logic tx_on);
      logic b;
      logic [7:0] m;
      b = bp;
      for (int i = 0; i < 200 && bp === b; i++) begin
         @(posedge clock_i);
         #1;
      end
      repeat (3) @(posedge clock_i);
      #1;
      check(36'(bp), 36'(((cyc - rel_cyc) / LCDH) % 2));
      m = {8{1'(((cyc - rel_cyc - 1) / LCDH) % 2)}};
      check(36'({rxh, rxl}), 36'({SEG[rxw[7:4]] ^ m, SEG[rxw[3:0]] ^ m}));
      if (tx_on) check(36'({txh, txl}), 36'({SEG[txw[7:4]] ^ m, SEG[txw[3:0]] ^ m}));
   endtask : check_disp
   task automatic wait_start(output int t);
      int low;
      low = 0;
      for (int i = 0; i < 2 * DWELLC; i++) begin
         @(posedge clock_i);
         #1;
         if (rf_tx === 1'b1 && low >= 80) break;
         low = (rf_tx === 1'b0) ? low + 1 : 0;
      end
      t = cyc;
   endtask : wait_start
   task automatic t_vote();
      logic [11:0] w [8];
      w = '{12'h123, 12'h456, 12'h789, 12'hABC, {SYM_TAB[6], SYM_TAB[11]}, 12'h0F0,
         {SYM_TAB[6], SYM_TAB[11]}, 12'h555};
      for (int i = 0; i < 8; i++) begin
         u_rf.send_frame(w[i], (i < 4) ? BITC : BITC + 1);
         repeat (40) @(posedge clock_i);
         #1;
         if (i == 3) check(36'(valid), 36'h0);
      end
      check(36'(valid), 36'h1);
      check_disp(8'h6B, 8'h00, 1'b0);
   endtask : t_vote
   task automatic t_frame();
      logic [35:0] got;
      int t0, t1, t2, t3, t4;
      got = '0;
      for (int i = 0; i < 2000 && rf_tx !== 1'b1; i++) begin
         @(posedge clock_i);
         #1;
      end
      t0 = cyc;
      for (int b = 1; b < 36; b++) begin
         repeat ((b == 1) ? BITC / 2 : BITC) @(posedge clock_i);
         #1;
         got[b] = rf_tx;
      end
      check(got, {POSTAMBLE, SYM_TAB[12], SYM_TAB[0], PREAMBLE});
      wait_start(t1);
      check(36'(t1 - t0), 36'(GAPC));
      // freeze both halves for ten cycles
      ce_i = 1'b0;
      repeat (10) @(posedge clock_i);
      #1;
      ce_i = 1'b1;
      rel_cyc = rel_cyc + 10;
      wait_start(t2);
      check(36'(t2 - t1), 36'(GAPC + 10));
      wait_start(t3);
      check(36'(st), 36'h0);
      wait_start(t4);
      check(36'(st), 36'h1);
   endtask : t_frame
   task automatic t_display();
      int t;
      for (int k = 2; k < 9; k++) begin
         t = cyc;
         while (st !== 3'(k) && cyc - t < 2 * DWELLC) begin
            @(posedge clock_i);
            #1;
         end
         check_disp(MSG[k - 1], MSG[k % 8], 1'b1);
      end
   endtask : t_display
   initial begin
      sys_rst_i = 1'b1;
      ce_i = 1'b1;
      loop = 1'b0;
      do_reset();
      t_vote();
      loop = 1'b1;
      do_reset();
      t_frame();
      t_display();
      end_sim();
   end
endmodule : tb_top
